/* include/rtc_pkg.sv */
// constants, field layout and code tables of the receive timeslot conditioning block
// assumes byte-wide registers on a plain strobe port, one octet per line strobe
package rtc_pkg;

    // ==========================================================
    // geometry
    localparam int          NUM_TS      = 24;
    localparam int          ADDR_W      = 12;
    localparam int          TS_W        = 5;

    // ==========================================================
    // register offsets (byte addresses within the channel)
    localparam logic [11:0] ADDR_DE_SRC    = 12'h10c;
    localparam logic [11:0] ADDR_CTL_BASE  = 12'h360;
    localparam logic [11:0] ADDR_UCODE_BASE = 12'h380;
    localparam logic [11:0] ADDR_STAT_TS   = 12'h3c0;
    localparam logic [11:0] ADDR_STAT_OCT  = 12'h3c1;
    localparam logic [11:0] ADDR_STAT_CNT  = 12'h3c2;

    // ==========================================================
    // control word layout
    localparam int          CTL_LINK_MSB = 7;
    localparam int          CTL_LINK_LSB = 6;
    localparam int          CTL_ZERO_MSB = 5;
    localparam int          CTL_ZERO_LSB = 4;
    localparam int          CTL_COND_MSB = 3;
    localparam int          CTL_COND_LSB = 0;
    localparam int          DE_SRC_MSB   = 1;

    // ==========================================================
    // reset values
    localparam logic [7:0]  CTL_RESET    = 8'h80;
    localparam logic [7:0]  UCODE_RESET  = 8'hff;
    localparam logic [1:0]  DE_SRC_RESET = 2'h0;

    // ==========================================================
    // substitution codes and masks
    localparam logic [7:0]  DDS_CODE     = 8'h98;
    localparam logic [7:0]  STUFF_BIT7   = 8'h02;
    localparam logic [7:0]  STUFF_BIT8   = 8'h01;
    localparam logic [7:0]  MASK_ALL     = 8'hff;
    localparam logic [7:0]  MASK_EVEN    = 8'haa;
    localparam logic [7:0]  MASK_ODD     = 8'h55;
    localparam logic [7:0]  BUSY_CODE    = 8'h7f;
    localparam logic [7:0]  VACANT_CODE  = 8'hff;
    localparam logic [7:0]  OOF_CODE     = 8'h1a;
    localparam logic [2:0]  BUSY_TS_HEAD = 3'h7;

    // ==========================================================
    // field encodings
    typedef enum logic [1:0] {
        RTC_LINK_CTRL1  = 2'b00,
        RTC_LINK_CTRL2  = 2'b01,
        RTC_LINK_DE_SRC = 2'b10,
        RTC_LINK_CTRL3  = 2'b11
    } rtc_link_sel_t;

    typedef enum logic [1:0] {
        RTC_ZCS_NONE = 2'b00,
        RTC_ZCS_BIT7 = 2'b01,
        RTC_ZCS_ALT  = 2'b10,
        RTC_ZCS_DDS  = 2'b11
    } rtc_zcs_t;

    typedef enum logic [3:0] {
        RTC_COND_PASS     = 4'b0000,
        RTC_COND_INVERT   = 4'b0001,
        RTC_COND_EVEN     = 4'b0010,
        RTC_COND_ODD      = 4'b0011,
        RTC_COND_USER     = 4'b0100,
        RTC_COND_BUSY     = 4'b0101,
        RTC_COND_VACANT   = 4'b0110,
        RTC_COND_BUSY_TS  = 4'b0111,
        RTC_COND_OOF      = 4'b1000,
        RTC_COND_PASS_ALT = 4'b1110
    } rtc_cond_t;

endpackage

/* design/rtc_octet_cond.sv */
// one-octet datapath: zero-code suppression followed by conditioning
// assumes the caller registers the result; purely combinational
`timescale 1ns/100ps

module rtc_octet_cond
    import rtc_pkg::*;
(
    input  wire logic [7:0]      octet_i,
    input  wire logic [7:0]      ctl_i,
    input  wire logic [7:0]      user_code_i,
    input  wire logic [TS_W-1:0] ts_i,
    input  wire logic            sig_frame_i,
    output logic      [7:0]      octet_o
);

    rtc_zcs_t   zcs;
    rtc_cond_t  cond;
    logic [7:0] zcs_octet;

    assign zcs  = rtc_zcs_t'(ctl_i[CTL_ZERO_MSB:CTL_ZERO_LSB]);
    assign cond = rtc_cond_t'(ctl_i[CTL_COND_MSB:CTL_COND_LSB]);

    // ==========================================================
    // zero-code suppression, only an all-zero octet is touched
    always_comb begin
        zcs_octet = octet_i;
        if (octet_i == 8'h00) begin
            unique case (zcs)
                RTC_ZCS_NONE: zcs_octet = octet_i;
                RTC_ZCS_BIT7: zcs_octet = STUFF_BIT7;
                // signaling bit lies in an all-zero octet, so it is zero
                RTC_ZCS_ALT:  zcs_octet = sig_frame_i ? STUFF_BIT7 : STUFF_BIT8;
                RTC_ZCS_DDS:  zcs_octet = DDS_CODE;
            endcase
        end
    end

    // ==========================================================
    // conditioning; unlisted codes leave the octet unchanged
    always_comb begin
        unique case (cond)
            RTC_COND_PASS,
            RTC_COND_PASS_ALT: octet_o = zcs_octet;
            RTC_COND_INVERT:   octet_o = zcs_octet ^ MASK_ALL;
            RTC_COND_EVEN:     octet_o = zcs_octet ^ MASK_EVEN;
            RTC_COND_ODD:      octet_o = zcs_octet ^ MASK_ODD;
            RTC_COND_USER:     octet_o = user_code_i;
            RTC_COND_BUSY:     octet_o = BUSY_CODE;
            RTC_COND_VACANT:   octet_o = VACANT_CODE;
            RTC_COND_BUSY_TS:  octet_o = {BUSY_TS_HEAD, ts_i};
            RTC_COND_OOF:      octet_o = OOF_CODE;
            default:           octet_o = zcs_octet;
        endcase
    end

endmodule

/* design/rtc_rx_ts_cond.sv */
// receive per-timeslot control: register file, octet conditioning, D/E routing
// assumes one octet per rx_octet_valid_i strobe, timeslot number beside it,
// and a register master that never asserts both strobes at once
//
// Overview of operation
// - select field 00, 01, 11 routes D/E octet to controller 1, 2, 3.
// - select field 10 takes the D/E source from the D/E source register.
// - zero suppression 00 leaves the octet unsuppressed.
// - zero suppression 01 stuffs bit 7 into an all-zero octet.
// - suppression 10 stuffs bit 8, or bit 7 in signaling frames.
// - suppression 11 replaces the zero octet with 0x98.
// - conditioning 0x0 or 0xE passes the octet unchanged.
// - conditioning 0x1 outputs the octet XOR 0xFF.
// - conditioning 0x2 outputs the octet XOR 0xAA.
// - conditioning 0x3 outputs the octet XOR 0x55.
// - conditioning 0x4 outputs that timeslot's programmable user code.
// - conditioning applies per timeslot before the octet reaches the backplane.
// - one control word per timeslot, 24 consecutive byte registers.
// - conditioning 0x5 outputs busy code 0x7F.
// - conditioning 0x6 outputs vacant code 0xFF.
// - conditioning 0x7 outputs three ones then the timeslot number.
// - conditioning 0x8 outputs out-of-frame code 0x1A.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps

module rtc_rx_ts_cond
    import rtc_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [7:0]        reg_rdata_o,
    // received line octets
    input  wire logic              rx_octet_valid_i,
    input  wire logic [7:0]        rx_octet_i,
    input  wire logic [TS_W-1:0]   rx_ts_i,
    input  wire logic              rx_sig_frame_i,
    input  wire logic              rx_de_slot_i,
    // backplane side
    output logic                   bp_valid_o,
    output logic      [7:0]        bp_octet_o,
    output logic      [TS_W-1:0]   bp_ts_o,
    // link message controllers and D/E source
    output logic      [2:0]        msg_valid_o,
    output logic      [7:0]        msg_octet_o,
    output logic                   de_src_valid_o,
    output logic      [1:0]        de_src_sel_o
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [NUM_TS-1:0][7:0] ctl;
        logic [NUM_TS-1:0][7:0] ucode;
        logic [1:0]             de_src;
        logic [7:0]             rdata;
        logic                   bp_valid;
        logic [7:0]             bp_octet;
        logic [TS_W-1:0]        bp_ts;
        logic [2:0]             msg_valid;
        logic [7:0]             msg_octet;
        logic                   de_valid;
        logic [1:0]             de_sel;
        logic [TS_W-1:0]        last_ts;
        logic [7:0]             last_octet;
        logic [7:0]             octet_cnt;
    } rtc_state_t;

    rtc_state_t          state_reg;
    rtc_state_t          state_next;

    logic [NUM_TS-1:0]   ctl_wr_hit;
    logic [NUM_TS-1:0]   ucode_wr_hit;
    logic [NUM_TS-1:0]   ctl_rd_hit;
    logic [NUM_TS-1:0]   ucode_rd_hit;
    logic                de_wr_hit;
    logic                octet_take;
    logic [7:0]          cur_ctl;
    logic [7:0]          cur_ucode;
    logic [7:0]          cond_octet;
    rtc_link_sel_t       cur_link;
    logic [7:0]          rd_value;

    // ==========================================================
    // address decode, one comparator pair per timeslot
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TS; gi++) begin : g_decode
            localparam logic [ADDR_W-1:0] CTL_ADDR   = ADDR_W'(ADDR_CTL_BASE + gi);
            localparam logic [ADDR_W-1:0] UCODE_ADDR = ADDR_W'(ADDR_UCODE_BASE + gi);
            assign ctl_rd_hit[gi]   = (reg_addr_i == CTL_ADDR);
            assign ucode_rd_hit[gi] = (reg_addr_i == UCODE_ADDR);
            assign ctl_wr_hit[gi]   = reg_wr_i && ctl_rd_hit[gi];
            assign ucode_wr_hit[gi] = reg_wr_i && ucode_rd_hit[gi];
        end
    endgenerate

    assign de_wr_hit = reg_wr_i && (reg_addr_i == ADDR_DE_SRC);

    // ==========================================================
    // octet path
    // out-of-range timeslot numbers are dropped, not indexed
    assign octet_take = rx_octet_valid_i && (rx_ts_i < TS_W'(NUM_TS));

    // control word read from the registered copy, so a write landing in
    // the same cycle as the octet is seen only from the next octet on
    always_comb begin
        cur_ctl   = CTL_RESET;
        cur_ucode = UCODE_RESET;
        if (octet_take) begin
            cur_ctl   = state_reg.ctl[rx_ts_i];
            cur_ucode = state_reg.ucode[rx_ts_i];
        end
    end

    assign cur_link = rtc_link_sel_t'(cur_ctl[CTL_LINK_MSB:CTL_LINK_LSB]);

    rtc_octet_cond u_octet_cond (
        .octet_i     (rx_octet_i),
        .ctl_i       (cur_ctl),
        .user_code_i (cur_ucode),
        .ts_i        (rx_ts_i),
        .sig_frame_i (rx_sig_frame_i),
        .octet_o     (cond_octet)
    );

    // ==========================================================
    // read mux; unmapped addresses read zero
    always_comb begin
        rd_value = 8'h00;
        for (int i = 0; i < NUM_TS; i++) begin
            if (ctl_rd_hit[i]) begin
                rd_value = state_reg.ctl[i];
            end
            if (ucode_rd_hit[i]) begin
                rd_value = state_reg.ucode[i];
            end
        end
        if (reg_addr_i == ADDR_DE_SRC) begin
            rd_value = {6'h00, state_reg.de_src};
        end
        if (reg_addr_i == ADDR_STAT_TS) begin
            rd_value = {3'h0, state_reg.last_ts};
        end
        if (reg_addr_i == ADDR_STAT_OCT) begin
            rd_value = state_reg.last_octet;
        end
        if (reg_addr_i == ADDR_STAT_CNT) begin
            rd_value = state_reg.octet_cnt;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;

        // read data stands only in the cycle after the strobe
        state_next.rdata = reg_rd_i ? rd_value : 8'h00;

        // register writes
        for (int i = 0; i < NUM_TS; i++) begin
            if (ctl_wr_hit[i]) begin
                state_next.ctl[i] = reg_wdata_i;
            end
            if (ucode_wr_hit[i]) begin
                state_next.ucode[i] = reg_wdata_i;
            end
        end
        if (de_wr_hit) begin
            state_next.de_src = reg_wdata_i[DE_SRC_MSB:0];
        end

        // strobes default low
        state_next.bp_valid  = 1'b0;
        state_next.msg_valid = 3'h0;
        state_next.de_valid  = 1'b0;

        if (octet_take) begin
            // every accepted octet reaches the backplane conditioned
            state_next.bp_valid   = 1'b1;
            state_next.bp_octet   = cond_octet;
            state_next.bp_ts      = rx_ts_i;
            state_next.last_ts    = rx_ts_i;
            state_next.last_octet = cond_octet;
            state_next.octet_cnt  = state_reg.octet_cnt + 8'h01;

            // D/E octets also go raw to the selected message path
            if (rx_de_slot_i) begin
                state_next.msg_octet = rx_octet_i;
                unique case (cur_link)
                    RTC_LINK_CTRL1:  state_next.msg_valid = 3'b001;
                    RTC_LINK_CTRL2:  state_next.msg_valid = 3'b010;
                    RTC_LINK_CTRL3:  state_next.msg_valid = 3'b100;
                    RTC_LINK_DE_SRC: begin
                        state_next.de_valid = 1'b1;
                        state_next.de_sel   = state_reg.de_src;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_TS; i++) begin
                state_reg.ctl[i]   <= CTL_RESET;
                state_reg.ucode[i] <= UCODE_RESET;
            end
            state_reg.de_src     <= DE_SRC_RESET;
            state_reg.rdata      <= 8'h00;
            state_reg.bp_valid   <= 1'b0;
            state_reg.bp_octet   <= 8'h00;
            state_reg.bp_ts      <= '0;
            state_reg.msg_valid  <= 3'h0;
            state_reg.msg_octet  <= 8'h00;
            state_reg.de_valid   <= 1'b0;
            state_reg.de_sel     <= 2'h0;
            state_reg.last_ts    <= '0;
            state_reg.last_octet <= 8'h00;
            state_reg.octet_cnt  <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    assign reg_rdata_o    = state_reg.rdata;
    assign bp_valid_o     = state_reg.bp_valid;
    assign bp_octet_o     = state_reg.bp_octet;
    assign bp_ts_o        = state_reg.bp_ts;
    assign msg_valid_o    = state_reg.msg_valid;
    assign msg_octet_o    = state_reg.msg_octet;
    assign de_src_valid_o = state_reg.de_valid;
    assign de_src_sel_o   = state_reg.de_sel;

endmodule

/* testbench/rtc_rx_ts_cond_monitor.sv */
// assertion checker for the receive timeslot conditioning block
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/100ps

module rtc_rx_ts_cond_monitor
    import rtc_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [7:0]        reg_rdata_o,
    input  wire logic              rx_octet_valid_i,
    input  wire logic [7:0]        rx_octet_i,
    input  wire logic [TS_W-1:0]   rx_ts_i,
    input  wire logic              rx_de_slot_i,
    input  wire logic              bp_valid_o,
    input  wire logic [7:0]        bp_octet_o,
    input  wire logic [TS_W-1:0]   bp_ts_o,
    input  wire logic [2:0]        msg_valid_o,
    input  wire logic [7:0]        msg_octet_o,
    input  wire logic              de_src_valid_o
);
    // ==========================================================
    // shadow control words, old word seen by a same-cycle octet
    logic [7:0] shadow_reg [NUM_TS];
    logic [3:0] cond_reg;
    logic       take;
    assign take = rx_octet_valid_i && (rx_ts_i < 5'd24);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_TS; i++)
                shadow_reg[i] <= CTL_RESET;
        end else if (reg_wr_i && reg_addr_i >= ADDR_CTL_BASE
                     && reg_addr_i < ADDR_CTL_BASE + 12'd24) begin
            shadow_reg[reg_addr_i - ADDR_CTL_BASE] <= reg_wdata_i;
        end
        cond_reg <= take ? shadow_reg[rx_ts_i][3:0] : 4'h0;
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    AST_BP_LATENCY: assert property (take |=> bp_valid_o)
        else $error("accepted octet not delivered next cycle");
    AST_BP_DROP: assert property (!take |=> !bp_valid_o)
        else $error("delivery without an accepted octet");
    AST_BP_TS: assert property (bp_valid_o |-> bp_ts_o == $past(rx_ts_i))
        else $error("delivered timeslot number wrong");
    AST_BUSY: assert property (bp_valid_o && cond_reg == 4'h5 |-> bp_octet_o == 8'h7f)
        else $error("busy code wrong");
    AST_VACANT: assert property (bp_valid_o && cond_reg == 4'h6 |-> bp_octet_o == 8'hff)
        else $error("vacant code wrong");
    AST_BUSY_TS: assert property (bp_valid_o && cond_reg == 4'h7 |-> bp_octet_o == {3'h7, bp_ts_o})
        else $error("busy timeslot code wrong");
    AST_OOF: assert property (bp_valid_o && cond_reg == 4'h8 |-> bp_octet_o == 8'h1a)
        else $error("out of frame code wrong");
    AST_INVERT: assert property (bp_valid_o && cond_reg == 4'h1 && $past(rx_octet_i) != 8'h00
        |-> bp_octet_o == ~$past(rx_octet_i))
        else $error("inverted octet wrong");
    AST_MSG_SRC: assert property (|msg_valid_o |-> $past(rx_de_slot_i)
        && msg_octet_o == $past(rx_octet_i))
        else $error("message octet without a matching D/E octet");
    AST_MSG_EXCL: assert property ($onehot0({msg_valid_o, de_src_valid_o}))
        else $error("D/E octet routed to more than one place");
    AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside the read answer cycle");
    COV_BP: cover property (bp_valid_o && cond_reg == 4'h7);
    COV_MSG: cover property (msg_valid_o == 3'b100);
    COV_DE: cover property (de_src_valid_o);
endmodule

/* testbench/rtc_bp_sink.sv */
// backplane receiver model: counts conditioned octets, keeps the last
// assumes the block's registered one-cycle delivery pulse
`timescale 1ns/100ps

module rtc_bp_sink (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic        bp_valid_i,
    input  wire logic [7:0]  bp_octet_i,
    output logic      [15:0] rx_count_o,
    output logic      [7:0]  last_octet_o
);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rx_count_o   <= 16'h0000;
            last_octet_o <= 8'h00;
        end else if (bp_valid_i) begin
            rx_count_o   <= rx_count_o + 16'h0001;
            last_octet_o <= bp_octet_i;
        end
    end
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the receive timeslot conditioning block
// assumes the register port answers reads one cycle after the strobe
`timescale 1ns/100ps

module tb_top
    import rtc_pkg::*;
;
    logic sys_clk_i, reset_i, reg_wr_i, reg_rd_i, rx_octet_valid_i, rx_sig_frame_i, rx_de_slot_i;
    logic [11:0] reg_addr_i;
    logic [7:0]  reg_wdata_i, rx_octet_i, reg_rdata_o, bp_octet_o, msg_octet_o, last_octet;
    logic [4:0]  rx_ts_i, bp_ts_o;
    logic [2:0]  msg_valid_o;
    logic [1:0]  de_src_sel_o;
    logic        bp_valid_o, de_src_valid_o;
    logic [15:0] sink_count;
    logic [7:0]  accepted;
    int          mismatches, samples_checked;

    rtc_rx_ts_cond uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .rx_octet_valid_i(rx_octet_valid_i),
        .rx_octet_i(rx_octet_i), .rx_ts_i(rx_ts_i), .rx_sig_frame_i(rx_sig_frame_i),
        .rx_de_slot_i(rx_de_slot_i), .bp_valid_o(bp_valid_o), .bp_octet_o(bp_octet_o),
        .bp_ts_o(bp_ts_o), .msg_valid_o(msg_valid_o), .msg_octet_o(msg_octet_o),
        .de_src_valid_o(de_src_valid_o), .de_src_sel_o(de_src_sel_o));
    rtc_bp_sink sink (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bp_valid_i(bp_valid_o),
        .bp_octet_i(bp_octet_o), .rx_count_o(sink_count), .last_octet_o(last_octet));

    // ==========================================================
    // bus and compare tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("reg_rdata_o", e, reg_rdata_o);
    endtask
    task automatic send(input logic [4:0] ts, input logic [7:0] oct, input logic sig,
                        input logic de, input logic ev, input logic [7:0] eo);
        @(posedge sys_clk_i);
        rx_octet_valid_i <= 1'b1;
        rx_ts_i          <= ts;
        rx_octet_i       <= oct;
        rx_sig_frame_i   <= sig;
        rx_de_slot_i     <= de;
        @(posedge sys_clk_i);
        rx_octet_valid_i <= 1'b0;
        #1 chk("bp_valid_o", {7'h00, ev}, {7'h00, bp_valid_o});
        if (ev) begin
            chk("bp_octet_o", eo, bp_octet_o);
            chk("bp_ts_o", {3'h0, ts}, {3'h0, bp_ts_o});
            accepted++;
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset;
        rd(ADDR_CTL_BASE, 8'h80);
        rd(ADDR_CTL_BASE + 12'd23, 8'h80);
        rd(ADDR_UCODE_BASE, 8'hff);
        rd(ADDR_DE_SRC, 8'h00);
        wr(12'h378, 8'h55);
        rd(12'h378, 8'h00);
        wr(ADDR_CTL_BASE + 12'd23, 8'h41);
        rd(ADDR_CTL_BASE + 12'd23, 8'h41);
        $display("t_reset done");
    endtask
    task automatic t_cond;
        logic [3:0] code [10] = '{4'h0, 4'he, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
        logic [7:0] exp [10] = '{8'h5a, 8'h5a, 8'ha5, 8'hf0, 8'h0f, 8'h3c, 8'h7f, 8'hff,
                                 8'he7, 8'h1a};
        wr(ADDR_UCODE_BASE + 12'd4, 8'h3c);
        rd(ADDR_UCODE_BASE + 12'd4, 8'h3c);
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_CTL_BASE + {8'h00, code[i]}, {4'h0, code[i]});
            send({1'b0, code[i]}, 8'h5a, 1'b0, 1'b0, 1'b1, exp[i]);
        end
        $display("t_cond done");
    endtask
    task automatic t_zcs;
        logic [1:0] zs [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
        logic [7:0] exp [5] = '{8'h00, 8'h02, 8'h01, 8'h98, 8'h02};
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CTL_BASE + 12'd9, {2'h0, zs[i], 4'h0});
            send(5'd9, 8'h00, i == 4, 1'b0, 1'b1, exp[i]);
        end
        $display("t_zcs done");
    endtask
    task automatic t_de;
        logic [2:0] ev [4] = '{3'b001, 3'b010, 3'b000, 3'b100};
        wr(ADDR_DE_SRC, 8'h03);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CTL_BASE + 12'd10, {s[1:0], 6'h00});
            send(5'd10, 8'h33, 1'b0, 1'b1, 1'b1, 8'h33);
            chk("msg_valid_o", {5'h00, ev[s]}, {5'h00, msg_valid_o});
            chk("de_src_valid_o", {7'h00, s == 2}, {7'h00, de_src_valid_o});
            if (s == 2)
                chk("de_src_sel_o", 8'h03, {6'h00, de_src_sel_o});
            else
                chk("msg_octet_o", 8'h33, msg_octet_o);
        end
        $display("t_de done");
    endtask
    task automatic t_switch;
        send(5'd24, 8'h11, 1'b0, 1'b0, 1'b0, 8'h00);
        // slot 23 still holds the invert word left by t_reset
        send(5'd23, 8'h11, 1'b0, 1'b0, 1'b1, 8'hee);
        @(posedge sys_clk_i);
        reg_wr_i         <= 1'b1;
        reg_addr_i       <= ADDR_CTL_BASE + 12'd11;
        reg_wdata_i      <= 8'h01;
        rx_octet_valid_i <= 1'b1;
        rx_ts_i          <= 5'd11;
        rx_octet_i       <= 8'h3c;
        rx_de_slot_i     <= 1'b0;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        #1 chk("bp_octet_o", 8'h3c, bp_octet_o);
        @(posedge sys_clk_i);
        rx_octet_valid_i <= 1'b0;
        #1 chk("bp_octet_o", 8'hc3, bp_octet_o);
        accepted += 8'd2;
        $display("t_switch done");
    endtask
    task automatic t_status;
        // sink registers the last delivery pulse one edge later
        @(posedge sys_clk_i);
        #1 chk("sink count", accepted, sink_count[7:0]);
        chk("sink last", 8'hc3, last_octet);
        rd(ADDR_STAT_TS, 8'h0b);
        rd(ADDR_STAT_OCT, 8'hc3);
        rd(ADDR_STAT_CNT, accepted);
        $display("t_status done");
    endtask

    // ==========================================================
    // run control
    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        {reg_wr_i, reg_rd_i, rx_octet_valid_i, rx_sig_frame_i, rx_de_slot_i} = 5'h00;
        {reg_addr_i, reg_wdata_i, rx_octet_i, rx_ts_i} = 33'h0;
        {mismatches, samples_checked, accepted} = '0;
        reset_i = 1'b1;
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        t_reset;
        t_cond;
        t_zcs;
        t_de;
        t_switch;
        t_status;
        conclude;
    end
    // bounds the whole run; a hang counts against the verdict
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        mismatches++;
        $display("run limit reached");
        conclude;
    end
endmodule

bind rtc_rx_ts_cond rtc_rx_ts_cond_monitor u_mon (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_octet_valid_i(rx_octet_valid_i),
    .rx_octet_i(rx_octet_i), .rx_ts_i(rx_ts_i), .rx_de_slot_i(rx_de_slot_i),
    .bp_valid_o(bp_valid_o), .bp_octet_o(bp_octet_o), .bp_ts_o(bp_ts_o),
    .msg_valid_o(msg_valid_o), .msg_octet_o(msg_octet_o), .de_src_valid_o(de_src_valid_o));
